// ---- src/lonx_map.vh ----
// instruction field positions, opcodes and widths for the logic/next-address executor
// included by the design files; definitions only
`ifndef LONX_MAP_VH
`define LONX_MAP_VH
`define LONX_A_HI        31
`define LONX_A_LO        27
`define LONX_B_HI        26
`define LONX_B_LO        22
`define LONX_C_HI        21
`define LONX_C_LO        17
`define LONX_OPX_HI      16
`define LONX_OPX_LO      11
`define LONX_LOW_HI      10
`define LONX_LOW_LO      6
`define LONX_IMM_HI      21
`define LONX_IMM_LO      6
`define LONX_OP_HI       5
`define LONX_OP_LO       0
`define LONX_OP_RTYPE    6'h3A
`define LONX_OP_ORHI     6'h34
`define LONX_OP_ORI      6'h14
`define LONX_OP_ADD_OPX  6'h31
`define LONX_OPX_NEXTPC  6'h1C
`define LONX_OPX_NOR     6'h06
`define LONX_OPX_OR      6'h16
`define LONX_PC_STEP     32'h00000004
`define LONX_HALF_ZERO   16'h0000
`define LONX_REG_ZERO    5'h00
`define LONX_LOW_ZERO    5'h00
`define LONX_WORD_ZERO   32'h00000000
`endif

// ---- src/lonx_regfile.v ----
// general register file: two registered read ports, one write port
// assumes the executor applies writes; register zero is never written
`timescale 1ns/1ns
`default_nettype none
`include "lonx_map.vh"
module lonx_regfile #(
  parameter DATA_W = 32,
  parameter ADDR_W = 5
) (
  input  wire              ref_clk,
  input  wire              rst,
  input  wire [ADDR_W-1:0] rd_a_addr,
  input  wire [ADDR_W-1:0] rd_b_addr,
  output reg  [DATA_W-1:0] rd_a_data,
  output reg  [DATA_W-1:0] rd_b_data,
  input  wire              wr_en,
  input  wire [ADDR_W-1:0] wr_addr,
  input  wire [DATA_W-1:0] wr_data
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1]; // word array
  integer i;
  // write port, zero register held clear, read data registered
  always @(posedge ref_clk) begin
    if (rst) begin
      for (i = 0; i < (1<<ADDR_W); i = i + 1) begin
        mem_reg[i] <= {DATA_W{1'b0}};
      end
      rd_a_data <= {DATA_W{1'b0}};
      rd_b_data <= {DATA_W{1'b0}};
    end else begin
      if (wr_en && (wr_addr != {ADDR_W{1'b0}})) begin
        mem_reg[wr_addr] <= wr_data;
      end
      rd_a_data <= mem_reg[rd_a_addr];
      rd_b_data <= mem_reg[rd_b_addr];
    end
  end
endmodule
`default_nettype wire

// ---- src/lonx_exec.v ----
// decoder and executor for next-address, nor, or, or-immediate high and low
// assumes fetch presents one instruction with its address and a valid strobe,
// holding both until the edge where instr_ready is also high;
// each instruction takes two cycles (operand read, then write back);
// the register file sits inside, the wb_* outputs mirror every write it takes
`timescale 1ns/1ns
`default_nettype none
`include "lonx_map.vh"
// Function
// - nextpc writes instruction address plus four
// - nextpc: R-type 0x3a, opx 0x1c, A=B=0
// - only nextpc exposes program counter to registers
// - nop changes no architectural state
// - nor writes inverse of A or B
// - or writes A or B
// - orhi ORs immediate into high halfword
// - ori ORs zero-extended immediate into low half
// - ori immediate is unsigned, never sign-extended
module lonx_exec #(
  parameter DATA_W = 32
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        instr_valid,
  input  wire [31:0] instr_word,
  input  wire [31:0] instr_addr,
  output reg         instr_ready,
  output reg         done_pulse,
  output reg         illegal_pulse,
  output reg         wb_en,
  output reg  [4:0]  wb_addr,
  output reg  [31:0] wb_data
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  // one-hot state codes
  localparam [1:0] ST_IDLE = 2'b01; // waiting for instruction
  localparam [1:0] ST_EXEC = 2'b10; // operands arriving from file
  // operation kinds: a plain binary tag, not a state
  localparam [2:0] K_NONE  = 3'h0;
  localparam [2:0] K_NEXT  = 3'h1;
  localparam [2:0] K_NOR   = 3'h2;
  localparam [2:0] K_OR    = 3'h3;
  localparam [2:0] K_ORHI  = 3'h4;
  localparam [2:0] K_ORI   = 3'h5;
  localparam [2:0] K_NOP   = 3'h6;

  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  // every field sits at a fixed place in the word; decode never shifts
  wire [4:0]  fld_a = instr_word[`LONX_A_HI:`LONX_A_LO];
  wire [4:0]  fld_b = instr_word[`LONX_B_HI:`LONX_B_LO];
  wire [4:0]  fld_c = instr_word[`LONX_C_HI:`LONX_C_LO];
  wire [5:0]  fld_opx = instr_word[`LONX_OPX_HI:`LONX_OPX_LO];
  wire [4:0]  fld_low = instr_word[`LONX_LOW_HI:`LONX_LOW_LO];
  wire [15:0] immediate_field_16 = instr_word[`LONX_IMM_HI:`LONX_IMM_LO];
  wire [5:0]  fld_op = instr_word[`LONX_OP_HI:`LONX_OP_LO];

  // ----------------------------------------
  // working registers
  // ----------------------------------------
  reg [1:0]  state_reg, state_next;
  reg [2:0]  kind_reg;      // decoded operation
  reg [4:0]  dest_reg;      // destination index
  reg [15:0] imm_reg;       // held immediate
  reg [31:0] pc_reg;        // held instruction address
  reg [2:0]  kind_dec;      // combinational decode
  reg [4:0]  dest_dec;
  wire [31:0] opnd_a;       // register file read data
  wire [31:0] opnd_b;
  reg [31:0] result;

  // ----------------------------------------
  // handshake
  // ----------------------------------------
  // a word counts only when both strobes are high; right after reset the
  // idle state shows instr_ready low for one cycle and must not take
  wire        take = instr_valid && instr_ready;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // only nextpc places pc_reg on the write path; no other kind reads it
  // words that match none of the forms below fall through to K_NONE, which
  // later raises illegal_pulse and blocks the write; a nonzero field in bits
  // 10..6 of an R-type word other than nop is treated as such a word
  always @* begin
    kind_dec = K_NONE;
    dest_dec = `LONX_REG_ZERO;
    if (fld_op == `LONX_OP_RTYPE) begin
      if (fld_opx == `LONX_OPX_NEXTPC && fld_a == `LONX_REG_ZERO &&
          fld_b == `LONX_REG_ZERO && fld_low == `LONX_LOW_ZERO) begin
        kind_dec = K_NEXT;
        dest_dec = fld_c;
      end else if (fld_opx == `LONX_OPX_NOR && fld_low == `LONX_LOW_ZERO) begin
        kind_dec = K_NOR;
        dest_dec = fld_c;
      end else if (fld_opx == `LONX_OPX_OR && fld_low == `LONX_LOW_ZERO) begin
        kind_dec = K_OR;
        dest_dec = fld_c;
      end else if (fld_opx == `LONX_OP_ADD_OPX && fld_a == `LONX_REG_ZERO &&
                   fld_b == `LONX_REG_ZERO && fld_c == `LONX_REG_ZERO) begin
        // recognised only so that it is not flagged; it has no destination
        kind_dec = K_NOP;
      end
    end else if (fld_op == `LONX_OP_ORHI) begin
      // I-type words name their destination in the B field
      kind_dec = K_ORHI;
      dest_dec = fld_b;
    end else if (fld_op == `LONX_OP_ORI) begin
      kind_dec = K_ORI;
      dest_dec = fld_b;
    end
  end

  // ----------------------------------------
  // execute
  // ----------------------------------------
  // result is formed in the exec cycle from the registered operands; the
  // immediate halves are glued with zero so no sign bit can leak upward
  always @* begin
    case (kind_reg)
      K_NEXT:  result = pc_reg + `LONX_PC_STEP;
      K_NOR:   result = ~(opnd_a | opnd_b);
      K_OR:    result = opnd_a | opnd_b;
      K_ORHI:  result = opnd_a | {imm_reg, `LONX_HALF_ZERO};
      K_ORI:   result = opnd_a | {`LONX_HALF_ZERO, imm_reg};
      // nop and unknown words produce zero; it is never written
      default: result = `LONX_WORD_ZERO;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // two states only: every instruction costs one idle and one exec cycle
  always @* begin
    case (state_reg)
      ST_IDLE: state_next = take ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_next = ST_IDLE;
      // an unused code drops back to idle
      default: state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // sequencing and output registers
  // ----------------------------------------
  // pulses fall back low every cycle; wb_addr and wb_data stand until the
  // next exec cycle, so an observer may read them late
  always @(posedge ref_clk) begin
    if (rst) begin
      // everything clears with the state, so no stale write survives reset
      state_reg     <= ST_IDLE;
      kind_reg      <= K_NONE;
      dest_reg      <= `LONX_REG_ZERO;
      imm_reg       <= `LONX_HALF_ZERO;
      pc_reg        <= `LONX_WORD_ZERO;
      instr_ready   <= 1'b0;
      done_pulse    <= 1'b0;
      illegal_pulse <= 1'b0;
      wb_en         <= 1'b0;
      wb_addr       <= `LONX_REG_ZERO;
      wb_data       <= `LONX_WORD_ZERO;
    end else begin
      state_reg     <= state_next;
      done_pulse    <= 1'b0;
      illegal_pulse <= 1'b0;
      wb_en         <= 1'b0;
      instr_ready   <= (state_next == ST_IDLE);
      case (state_reg)
        ST_IDLE: begin
          // latch all the exec cycle needs; fetch may move on after this edge
          if (take) begin
            kind_reg <= kind_dec;
            dest_reg <= dest_dec;
            imm_reg  <= immediate_field_16;
            pc_reg   <= instr_addr;
          end
        end
        ST_EXEC: begin
          // the exec cycle always ends the instruction, written or not
          done_pulse    <= 1'b1;
          illegal_pulse <= (kind_reg == K_NONE);
          // nop and unknown words write no register
          if (kind_reg != K_NONE && kind_reg != K_NOP && dest_reg != `LONX_REG_ZERO) begin
            wb_en <= 1'b1;
          end
          // address and data are captured even when no write follows
          wb_addr <= dest_reg;
          wb_data <= result;
        end
        default: begin
          // unreachable with one-hot codes; fall back to a harmless kind
          kind_reg <= K_NONE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // register file, read addresses straight from the fetched word
  // ----------------------------------------
  // the read is registered at the taking edge, while the word still stands;
  // a write lands one edge after done_pulse, so a dependent word taken in the
  // very next cycle would still see the old value
  lonx_regfile #(
    .DATA_W (DATA_W),
    .ADDR_W (5)
  ) u_rf (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .rd_a_addr (fld_a),
    .rd_b_addr (fld_b),
    .rd_a_data (opnd_a),
    .rd_b_data (opnd_b),
    .wr_en     (wb_en),
    .wr_addr   (wb_addr),
    .wr_data   (wb_data)
  );
endmodule
`default_nettype wire

// ---- sim/lonx_exec_checker.sv ----
// port checks for the executor
// bound to every lonx_exec instance
`timescale 1ns/1ns
`default_nettype none
module lonx_exec_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] instr_addr,
  input wire logic        instr_ready,
  input wire logic        done_pulse,
  input wire logic        illegal_pulse,
  input wire logic        wb_en,
  input wire logic [4:0]  wb_addr,
  input wire logic [31:0] wb_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------
  // decode helpers
  // ----------------
  wire logic tk = instr_valid && instr_ready;
  wire logic rt = tk && instr_word[5:0] == 6'h3A && instr_word[10:6] == 5'h00;
  wire logic a0 = instr_word[31:27] == 5'h00;
  wire logic ab0 = a0 && instr_word[26:22] == 5'h00;
  wire logic c0 = instr_word[21:17] == 5'h00;
  wire logic b0 = instr_word[26:22] == 5'h00;
  wire logic [5:0] opx = instr_word[16:11];
  // write back lands two edges after the take
  sequence s_wr; ##2 done_pulse && wb_en; endsequence
  sequence s_nowr; ##2 done_pulse && !wb_en; endsequence
  AST_NEXTPC: assert property (rt && opx == 6'h1C && ab0 && !c0 |-> s_wr ##0
    wb_data == $past(instr_addr, 2) + 32'h00000004) else $error("nextpc result wrong");
  AST_NEXTPC_AB: assert property (rt && opx == 6'h1C && !ab0 |-> s_nowr ##0 illegal_pulse)
    else $error("nextpc with operands accepted");
  AST_NOP: assert property (tk && instr_word == 32'h0001883A |-> s_nowr ##0 !illegal_pulse)
    else $error("nop misbehaved");
  AST_NOR: assert property (rt && opx == 6'h06 && ab0 && !c0 |-> s_wr ##0 wb_data == 32'hFFFFFFFF)
    else $error("nor of zeros wrong");
  AST_OR: assert property (rt && opx == 6'h16 && ab0 && !c0 |-> s_wr ##0 wb_data == 32'h00000000)
    else $error("or of zeros wrong");
  AST_ORHI: assert property (tk && instr_word[5:0] == 6'h34 && a0 && !b0 |-> s_wr ##0
    wb_data == {$past(instr_word[21:6], 2), 16'h0000}) else $error("orhi result wrong");
  AST_ORI: assert property (tk && instr_word[5:0] == 6'h14 && a0 && !b0 |-> s_wr ##0
    wb_data == {16'h0000, $past(instr_word[21:6], 2)} && wb_addr == $past(instr_word[26:22], 2))
    else $error("ori result wrong");
  AST_ZERO_DEST: assert property (wb_en |-> wb_addr != 5'h00) else $error("write to register zero");
endmodule
bind lonx_exec lonx_exec_checker u_chk (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
  .instr_word(instr_word), .instr_addr(instr_addr), .instr_ready(instr_ready), .done_pulse(done_pulse),
  .illegal_pulse(illegal_pulse), .wb_en(wb_en), .wb_addr(wb_addr), .wb_data(wb_data));
`default_nettype wire

// ---- sim/lonx_fetch_model.sv ----
// fetch stage model: offers one word per request, holds it until taken
// assumes req is a one-cycle pulse from the bench
`timescale 1ns/1ns
`default_nettype none
module lonx_fetch_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic [31:0] word_in,
  input  wire logic [31:0] addr_in,
  input  wire logic        instr_ready,
  output var  logic        instr_valid,
  output var  logic [31:0] instr_word,
  output var  logic [31:0] instr_addr
);
  // word turns to its inverse once taken, so a stale sample cannot look valid
  always @(posedge ref_clk) begin
    if (rst) begin
      instr_valid <= 1'b0;
    end else if (instr_valid && instr_ready) begin
      instr_valid <= 1'b0;
      instr_word  <= ~instr_word;
    end else if (req && !instr_valid) begin
      instr_valid <= 1'b1;
      instr_word  <= word_in;
      instr_addr  <= addr_in;
    end
  end
endmodule
`default_nettype wire

// ---- sim/logic_or_nextpc_exec_test.sv ----
// self-checking bench for the executor
// fetch model feeds words; results seen on the write-back mirror
`timescale 1ns/1ns
`default_nettype none
module logic_or_nextpc_exec_test;
  logic ref_clk, rst, req;
  logic [31:0] wd, ad, iw, ia, wb_data;
  logic iv, rdy, done, ill, wb_en;
  logic [4:0] wb_addr;
  integer n_mismatch = 0;
  integer n_checks = 0;
  lonx_fetch_model fm_u (.ref_clk(ref_clk), .rst(rst), .req(req), .word_in(wd), .addr_in(ad),
    .instr_ready(rdy), .instr_valid(iv), .instr_word(iw), .instr_addr(ia));
  lonx_exec dut_u (.ref_clk(ref_clk), .rst(rst), .instr_valid(iv), .instr_word(iw), .instr_addr(ia),
    .instr_ready(rdy), .done_pulse(done), .illegal_pulse(ill), .wb_en(wb_en), .wb_addr(wb_addr),
    .wb_data(wb_data));
  function automatic logic [31:0] rw(input logic [4:0] a, b, c, input logic [5:0] x);
    rw = {a, b, c, x, 5'h00, 6'h3A};
  endfunction
  function automatic logic [31:0] im(input logic [4:0] a, b, input logic [15:0] v, input logic [5:0] o);
    im = {a, b, v, o};
  endfunction
  task automatic chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one instruction, then a spare cycle so a dependent read sees the write
  task automatic run(input logic [31:0] w, a, input logic en, input logic [4:0] d,
                     input logic [31:0] x, input logic il);
    integer k;
    @(posedge ref_clk);
    req <= 1'b1;
    wd  <= w;
    ad  <= a;
    @(posedge ref_clk);
    req <= 1'b0;
    k = 0;
    while (k < 8) begin
      @(posedge ref_clk);
      #1;
      // the cycle after the take the executor must be busy
      if (k == 0) chk({31'h0, rdy}, 32'h0);
      if (done === 1'b1) k = 99;
      else k++;
    end
    chk({31'h0, k == 99}, 32'h1);
    // ready rises together with done
    chk({31'h0, rdy}, 32'h1);
    chk({31'h0, wb_en}, {31'h0, en});
    chk({31'h0, ill}, {31'h0, il});
    if (en) begin
      chk({27'h0, wb_addr}, {27'h0, d});
      chk(wb_data, x);
    end
  endtask
  task t_imm;
    run(im(0, 1, 16'h8001, 6'h14), 0, 1, 1, 32'h00008001, 0);
    run(im(0, 2, 16'h1234, 6'h34), 0, 1, 2, 32'h12340000, 0);
    run(im(1, 8, 16'hF000, 6'h34), 0, 1, 8, 32'hF0008001, 0);
    run(im(2, 9, 16'h00F0, 6'h14), 0, 1, 9, 32'h123400F0, 0);
  endtask
  task t_logic;
    run(rw(1, 2, 3, 6'h16), 0, 1, 3, 32'h12348001, 0);
    run(rw(1, 2, 4, 6'h06), 0, 1, 4, 32'hEDCB7FFE, 0);
    run(rw(0, 0, 6, 6'h06), 0, 1, 6, 32'hFFFFFFFF, 0);
    run(rw(1, 2, 7, 6'h16) | 32'h40, 0, 0, 0, 0, 1);
  endtask
  task t_pc;
    run(rw(0, 0, 5, 6'h1C), 32'h00000100, 1, 5, 32'h00000104, 0);
    run(rw(0, 0, 5, 6'h1C), 32'hFFFFFFFC, 1, 5, 32'h00000000, 0);
    run(rw(1, 0, 5, 6'h1C), 32'h00000100, 0, 0, 0, 1);
    run(rw(0, 0, 13, 6'h16), 32'h00000100, 1, 13, 32'h00000000, 0);
  endtask
  task t_zero;
    run(32'h0001883A, 0, 0, 0, 0, 0);
    run(im(0, 0, 16'hFFFF, 6'h14), 0, 0, 0, 0, 0);
    run(rw(0, 0, 12, 6'h16), 0, 1, 12, 32'h00000000, 0);
  endtask
  // mid-run reset: outputs clear, ready comes back one edge later, file reads zero
  task t_reset;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk({31'h0, rdy}, 32'h0);
    chk({31'h0, wb_en}, 32'h0);
    chk(wb_data, 32'h00000000);
    @(posedge ref_clk);
    #1;
    chk({31'h0, rdy}, 32'h1);
    run(rw(9, 8, 13, 6'h16), 0, 1, 13, 32'h00000000, 0);
  endtask
  task stop_test;
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  // sixteen runs of under ten cycles each; 2000 leaves ample room
  initial begin
    repeat (2000) @(posedge ref_clk);
    n_mismatch++;
    stop_test;
  end
  initial begin
    rst = 1;
    req = 0;
    wd = 0;
    ad = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_imm;
    t_logic;
    t_pc;
    t_zero;
    t_reset;
    stop_test;
  end
endmodule
`default_nettype wire
